// [hdl/sea_pkg.sv]
// Purpose: shared constants and types of the slave-bus memory access decoder
// Assumes: bytes arrive already deserialised from the slave bus engine
// Notes:   byte positions are logical, as seen in block transfers
`default_nettype none

package sea_pkg;

    // logical byte positions of the field sequence
    localparam logic [2:0] POS_CODE    = 3'h0;
    localparam logic [2:0] POS_COUNT   = 3'h1;
    localparam logic [2:0] POS_CMD     = 3'h2;
    localparam logic [2:0] POS_ADDR    = 3'h3;
    localparam logic [2:0] POS_OFF_LO  = 3'h4;
    localparam logic [2:0] POS_OFF_HI  = 3'h5;
    localparam logic [2:0] POS_DATA    = 3'h6;
    localparam logic [2:0] POS_LAST    = 3'h7;

    // command byte field positions
    localparam int CMD_OP_BIT          = 0;
    localparam int CMD_USA_BIT         = 1;
    localparam int CMD_NOACK_BIT       = 3;
    localparam int CMD_LOSTARB_BIT     = 4;
    localparam int CMD_MISPLACED_BIT   = 5;

    // error flag vector order: {misplaced, lost arbitration, no ack}
    localparam int ERR_NOACK           = 0;
    localparam int ERR_LOSTARB         = 1;
    localparam int ERR_MISPLACED       = 2;
    localparam int ERR_W               = 3;

    localparam logic       OP_WRITE    = 1'b0;
    localparam logic       OP_READ     = 1'b1;

    // reply: status, address, offset low, offset high, data follow the count
    localparam logic [7:0] REPLY_COUNT = 8'h05;

    // default command code that marks a memory access
    localparam logic [7:0] CODE_MEMORY = 8'h01;

    // consecutive lost arbitrations before giving up
    localparam int ARB_LIMIT           = 16;

    // reset values
    localparam logic [7:0] BYTE_RESET  = 8'h00;
    localparam logic [4:0] ARB_RESET   = 5'h00;

    // command word carried to the system domain: {cmd, addr, offHi, offLo, data}
    localparam int CMDW_W              = 40;
    // reply word carried to the link domain: {flags, read data}
    localparam int RESPW_W             = 11;

    typedef enum logic [1:0] {
        SEA_IDLE,
        SEA_WAIT,
        SEA_RETRY,
        SEA_REPLY
    } sea_state_t;

endpackage

`default_nettype wire

// [hdl/sea_cdc_word.sv]
// Purpose: toggle handshake that moves one word between two clocks
// Assumes: send is taken only while busy is low
// Notes:   source word is held until the far side has acknowledged it
`default_nettype none

module sea_cdc_word #(
    parameter int W = 8
) (
    input  wire logic         srcClk,
    input  wire logic         srcRst,
    input  wire logic         srcSend,
    input  wire logic [W-1:0] srcData,
    output logic              srcBusy,
    input  wire logic         dstClk,
    input  wire logic         dstRst,
    output logic              dstPulse,
    output logic [W-1:0]      dstData
);

    logic         reqTgl_ff, nxt_reqTgl;
    logic [W-1:0] held_ff,   nxt_held;
    logic         ackS1_ff,  ackS2_ff;
    logic         reqS1_ff,  reqS2_ff, reqS3_ff;
    logic         pulse_ff,  nxt_pulse;
    logic [W-1:0] data_ff,   nxt_data;

    // busy until the acknowledge toggle has come back
    assign srcBusy = reqTgl_ff != ackS2_ff;

    // source side: hold the word, flip the request
    always_comb begin
        nxt_reqTgl = reqTgl_ff;
        nxt_held   = held_ff;
        if (srcSend && !srcBusy) begin
            nxt_reqTgl = ~reqTgl_ff;
            nxt_held   = srcData;
        end
    end

    always_ff @(posedge srcClk) begin
        if (srcRst) begin
            reqTgl_ff <= 1'b0;
            held_ff   <= '0;
            ackS1_ff  <= 1'b0;
            ackS2_ff  <= 1'b0;
        end else begin
            reqTgl_ff <= nxt_reqTgl;
            held_ff   <= nxt_held;
            ackS1_ff  <= reqS3_ff;
            ackS2_ff  <= ackS1_ff;
        end
    end

    // destination side: word is stable once the toggle has been synced
    always_comb begin
        nxt_pulse = reqS2_ff != reqS3_ff;
        nxt_data  = nxt_pulse ? held_ff : data_ff;
    end

    always_ff @(posedge dstClk) begin
        if (dstRst) begin
            reqS1_ff <= 1'b0;
            reqS2_ff <= 1'b0;
            reqS3_ff <= 1'b0;
            pulse_ff <= 1'b0;
            data_ff  <= '0;
        end else begin
            reqS1_ff <= reqTgl_ff;
            reqS2_ff <= reqS1_ff;
            reqS3_ff <= reqS2_ff;
            pulse_ff <= nxt_pulse;
            data_ff  <= nxt_data;
        end
    end

    assign dstPulse = pulse_ff;
    assign dstData  = data_ff;

endmodule

`default_nettype wire

// [hdl/sea_access_decoder.sv]
// Purpose: decodes slave-bus memory access commands, runs them on the master bus
// Assumes: link inputs come from the slave bus engine on clkLink
// Notes:   link logic on clkLink, master bus handling on clk_sys
//
// Contract
// - fields start right after slave address byte
// - position zero carries the command code
// - byte count present only in block transfers
// - returned count includes the status byte
// - position two is the command byte
// - position four is offset low byte
// - position five is offset high byte
// - position six is data byte
// - command bit 0: 0 write, 1 read
// - bit 1 selects given or configured address
// - bit 3 flags unexpected nack, clear on read
// - bit 4 flags 16 lost arbitrations
// - bit 5 flags misplaced start or stop
// - flags mirror master bus status flags; here held until read, lost arbitration only after ARB_TRIES losses
`default_nettype none

module sea_access_decoder #(
    parameter logic [7:0] MEM_CODE  = sea_pkg::CODE_MEMORY,
    parameter int         ARB_TRIES = sea_pkg::ARB_LIMIT
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    // link side, on the slave bus clock
    input  wire logic                        clkLink,
    input  wire logic                        frameStart,
    input  wire logic                        frameStop,
    input  wire logic                        blockMode,
    input  wire logic                        rxValid,
    input  wire logic [7:0]                  rxByte,
    input  wire logic                        txReq,
    output logic [7:0]                       txByte,
    // configured memory bus address
    input  wire logic [6:0]                  memIntfAddr,
    // master bus engine
    output logic                             mstReq,
    output logic                             mstRead,
    output logic [6:0]                       mstAddr,
    output logic [15:0]                      mstOffset,
    output logic [7:0]                       mstWData,
    input  wire logic                        mstDone,
    input  wire logic [7:0]                  mstRData,
    input  wire logic                        mstNoAck,
    input  wire logic                        mstLostArb,
    input  wire logic                        mstMisplaced,
    // status
    output logic                             busy,
    output logic [sea_pkg::ERR_W-1:0]        errFlags
);
    import sea_pkg::*;

    // ---------------- link domain ----------------
    logic              rstL1_ff, rstLink_ff;
    logic [2:0]        cnt_ff,    nxt_cnt;
    logic [7:0]        seen_ff,   nxt_seen;
    logic              codeOk_ff, nxt_codeOk;
    logic [7:0]        count_ff,  nxt_count;
    logic [7:0]        cmd_ff,    nxt_cmd;
    logic [7:0]        addr_ff,   nxt_addr;
    logic [7:0]        offLo_ff,  nxt_offLo;
    logic [7:0]        offHi_ff,  nxt_offHi;
    logic [7:0]        data_ff,   nxt_data;
    logic              cmdSend_ff, nxt_cmdSend;
    logic [2:0]        txIdx_ff,  nxt_txIdx;
    logic [7:0]        txByte_ff, nxt_txByte;
    logic [ERR_W-1:0]  rFlags_ff, nxt_rFlags;
    logic [7:0]        rData_ff,  nxt_rData;
    logic [ERR_W-1:0]  pendClr_ff, nxt_pendClr;
    logic [2:0]        logPos;
    logic              cmdBusy, clrBusy, respPulse;
    logic [RESPW_W-1:0] respWord;

    // link reset, brought over from the system reset
    always_ff @(posedge clkLink) begin
        rstL1_ff   <= rst;
        rstLink_ff <= rstL1_ff;
    end

    // raw count to logical position; the count byte is skipped outside block mode
    always_comb begin
        if (blockMode || cnt_ff == POS_CODE) begin
            logPos = cnt_ff;
        end else begin
            logPos = (cnt_ff == POS_LAST) ? POS_LAST : cnt_ff + 3'h1;
        end
    end

    // status byte as returned: flags in 5:3, reserved bits zero
    function automatic logic [7:0] statusByte(input logic [7:0] c, input logic [ERR_W-1:0] f);
        logic [7:0] s;
        s = 8'h00;
        s[CMD_OP_BIT]        = c[CMD_OP_BIT];
        s[CMD_USA_BIT]       = c[CMD_USA_BIT];
        s[CMD_NOACK_BIT]     = f[ERR_NOACK];
        s[CMD_LOSTARB_BIT]   = f[ERR_LOSTARB];
        s[CMD_MISPLACED_BIT] = f[ERR_MISPLACED];
        return s;
    endfunction

    // field capture by logical position
    always_comb begin
        nxt_cnt     = cnt_ff;
        nxt_seen    = seen_ff;
        nxt_codeOk  = codeOk_ff;
        nxt_count   = count_ff;
        nxt_cmd     = cmd_ff;
        nxt_addr    = addr_ff;
        nxt_offLo   = offLo_ff;
        nxt_offHi   = offHi_ff;
        nxt_data    = data_ff;
        nxt_cmdSend = 1'b0;
        if (frameStart) begin
            nxt_cnt  = POS_CODE;
            nxt_seen = 8'h00;
        end else if (rxValid) begin
            nxt_seen[logPos] = 1'b1;
            case (logPos)
                POS_CODE:   nxt_codeOk = rxByte == MEM_CODE;
                POS_COUNT:  nxt_count  = rxByte;
                POS_CMD:    nxt_cmd    = rxByte;
                POS_ADDR:   nxt_addr   = rxByte;
                POS_OFF_LO: nxt_offLo  = rxByte;
                POS_OFF_HI: nxt_offHi  = rxByte;
                POS_DATA:   nxt_data   = rxByte;
                default:    nxt_seen   = seen_ff;
            endcase
            if (cnt_ff != POS_LAST) begin
                nxt_cnt = cnt_ff + 3'h1;
            end
        end else if (frameStop && codeOk_ff && seen_ff[POS_OFF_HI]) begin
            // a read needs no data byte; a write does
            if (cmd_ff[CMD_OP_BIT] == OP_READ || seen_ff[POS_DATA]) begin
                nxt_cmdSend = 1'b1;
            end
        end
    end

    always_ff @(posedge clkLink) begin
        if (rstLink_ff) begin
            cnt_ff     <= POS_CODE;
            seen_ff    <= 8'h00;
            codeOk_ff  <= 1'b0;
            count_ff   <= BYTE_RESET;
            cmd_ff     <= BYTE_RESET;
            addr_ff    <= BYTE_RESET;
            offLo_ff   <= BYTE_RESET;
            offHi_ff   <= BYTE_RESET;
            data_ff    <= BYTE_RESET;
            cmdSend_ff <= 1'b0;
        end else begin
            cnt_ff     <= nxt_cnt;
            seen_ff    <= nxt_seen;
            codeOk_ff  <= nxt_codeOk;
            count_ff   <= nxt_count;
            cmd_ff     <= nxt_cmd;
            addr_ff    <= nxt_addr;
            offLo_ff   <= nxt_offLo;
            offHi_ff   <= nxt_offHi;
            data_ff    <= nxt_data;
            cmdSend_ff <= nxt_cmdSend;
        end
    end

    // reply bytes; reading the status byte clears the flags it showed
    always_comb begin
        nxt_txIdx   = txIdx_ff;
        nxt_txByte  = txByte_ff;
        nxt_rFlags  = rFlags_ff;
        nxt_rData   = rData_ff;
        nxt_pendClr = clrBusy ? pendClr_ff : {ERR_W{1'b0}};
        if (frameStart) begin
            nxt_txIdx = blockMode ? POS_COUNT : POS_CMD;
        end else if (txReq) begin
            case (txIdx_ff)
                POS_COUNT:  nxt_txByte = REPLY_COUNT;
                POS_CMD: begin
                    nxt_txByte  = statusByte(cmd_ff, rFlags_ff);
                    nxt_rFlags  = {ERR_W{1'b0}};
                    nxt_pendClr = nxt_pendClr | rFlags_ff;
                end
                POS_ADDR:   nxt_txByte = addr_ff;
                POS_OFF_LO: nxt_txByte = offLo_ff;
                POS_OFF_HI: nxt_txByte = offHi_ff;
                POS_DATA:   nxt_txByte = rData_ff;
                default:    nxt_txByte = BYTE_RESET;
            endcase
            if (txIdx_ff != POS_LAST) begin
                nxt_txIdx = txIdx_ff + 3'h1;
            end
        end
        // a fresh reply wins over a clear in the same cycle
        if (respPulse) begin
            nxt_rFlags = respWord[RESPW_W-1 -: ERR_W];
            nxt_rData  = respWord[7:0];
        end
    end

    always_ff @(posedge clkLink) begin
        if (rstLink_ff) begin
            txIdx_ff   <= POS_CMD;
            txByte_ff  <= BYTE_RESET;
            rFlags_ff  <= '0;
            rData_ff   <= BYTE_RESET;
            pendClr_ff <= '0;
        end else begin
            txIdx_ff   <= nxt_txIdx;
            txByte_ff  <= nxt_txByte;
            rFlags_ff  <= nxt_rFlags;
            rData_ff   <= nxt_rData;
            pendClr_ff <= nxt_pendClr;
        end
    end

    assign txByte = txByte_ff;

    // ---------------- crossings ----------------
    logic               cmdPulse, clrPulse, respBusy;
    logic [CMDW_W-1:0]  cmdWord;
    logic [ERR_W-1:0]   clrMask;
    logic               respSend_ff, nxt_respSend;
    logic [ERR_W-1:0]   flags_ff, nxt_flags;
    logic [7:0]         rdata_ff, nxt_rdata;

    // command is dropped if the previous one is still in flight
    sea_cdc_word #(.W(CMDW_W)) uCmd (
        .srcClk   (clkLink),
        .srcRst   (rstLink_ff),
        .srcSend  (cmdSend_ff),
        .srcData  ({cmd_ff, addr_ff, offHi_ff, offLo_ff, data_ff}),
        .srcBusy  (cmdBusy),
        .dstClk   (clk_sys),
        .dstRst   (rst),
        .dstPulse (cmdPulse),
        .dstData  (cmdWord)
    );

    // pending mask is sent from the flop and zeroed only once taken, so none is lost
    sea_cdc_word #(.W(ERR_W)) uClr (
        .srcClk   (clkLink),
        .srcRst   (rstLink_ff),
        .srcSend  (|pendClr_ff),
        .srcData  (pendClr_ff),
        .srcBusy  (clrBusy),
        .dstClk   (clk_sys),
        .dstRst   (rst),
        .dstPulse (clrPulse),
        .dstData  (clrMask)
    );

    sea_cdc_word #(.W(RESPW_W)) uResp (
        .srcClk   (clk_sys),
        .srcRst   (rst),
        .srcSend  (respSend_ff),
        .srcData  ({flags_ff, rdata_ff}),
        .srcBusy  (respBusy),
        .dstClk   (clkLink),
        .dstRst   (rstLink_ff),
        .dstPulse (respPulse),
        .dstData  (respWord)
    );

    // ---------------- system domain ----------------
    sea_state_t         state_ff, nxt_state;
    logic [4:0]         tries_ff, nxt_tries;
    logic               req_ff,   nxt_req;
    logic               rd_ff,    nxt_rd;
    logic [6:0]         maddr_ff, nxt_maddr;
    logic [15:0]        moff_ff,  nxt_moff;
    logic [7:0]         mwd_ff,   nxt_mwd;
    logic [ERR_W-1:0]   setMask;

    // errors raised by the finishing access
    always_comb begin
        setMask = '0;
        if (state_ff == SEA_WAIT && mstDone) begin
            setMask[ERR_NOACK]     = mstNoAck;
            setMask[ERR_MISPLACED] = mstMisplaced;
            setMask[ERR_LOSTARB]   = mstLostArb
                                  && tries_ff == 5'(ARB_TRIES - 1);
        end
    end

    // access sequencer with arbitration retries
    always_comb begin
        nxt_state    = state_ff;
        nxt_tries    = tries_ff;
        nxt_req      = req_ff;
        nxt_rd       = rd_ff;
        nxt_maddr    = maddr_ff;
        nxt_moff     = moff_ff;
        nxt_mwd      = mwd_ff;
        nxt_rdata    = rdata_ff;
        nxt_respSend = 1'b0;
        case (state_ff)
            SEA_IDLE: begin
                if (cmdPulse) begin
                    nxt_rd    = cmdWord[32 + CMD_OP_BIT];
                    nxt_maddr = cmdWord[32 + CMD_USA_BIT] ? cmdWord[31:25]
                                                          : memIntfAddr;
                    nxt_moff  = cmdWord[23:8];
                    nxt_mwd   = cmdWord[7:0];
                    nxt_tries = ARB_RESET;
                    nxt_req   = 1'b1;
                    nxt_state = SEA_WAIT;
                end
            end
            SEA_WAIT: begin
                if (mstDone) begin
                    nxt_req = 1'b0;
                    if (mstLostArb && tries_ff != 5'(ARB_TRIES - 1)) begin
                        nxt_tries = tries_ff + 5'h01;
                        nxt_state = SEA_RETRY;
                    end else begin
                        if (rd_ff && !mstNoAck && !mstLostArb && !mstMisplaced) begin
                            nxt_rdata = mstRData;
                        end
                        nxt_state = SEA_REPLY;
                    end
                end
            end
            SEA_RETRY: begin
                nxt_req   = 1'b1;
                nxt_state = SEA_WAIT;
            end
            SEA_REPLY: begin
                // wait for the reply path to be free
                if (!respBusy) begin
                    nxt_respSend = 1'b1;
                    nxt_state    = SEA_IDLE;
                end
            end
            default: begin
                nxt_req   = 1'b0;
                nxt_state = SEA_IDLE;
            end
        endcase
    end

    // sticky flags: a new error wins over a clear in the same cycle
    always_comb begin
        nxt_flags = flags_ff;
        if (clrPulse) begin
            nxt_flags = flags_ff & ~clrMask;
        end
        nxt_flags = nxt_flags | setMask;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff    <= SEA_IDLE;
            tries_ff    <= ARB_RESET;
            req_ff      <= 1'b0;
            rd_ff       <= OP_WRITE;
            maddr_ff    <= 7'h00;
            moff_ff     <= 16'h0000;
            mwd_ff      <= BYTE_RESET;
            rdata_ff    <= BYTE_RESET;
            respSend_ff <= 1'b0;
            flags_ff    <= '0;
        end else begin
            state_ff    <= nxt_state;
            tries_ff    <= nxt_tries;
            req_ff      <= nxt_req;
            rd_ff       <= nxt_rd;
            maddr_ff    <= nxt_maddr;
            moff_ff     <= nxt_moff;
            mwd_ff      <= nxt_mwd;
            rdata_ff    <= nxt_rdata;
            respSend_ff <= nxt_respSend;
            flags_ff    <= nxt_flags;
        end
    end

    // outputs from flops, busy decoded from state; errFlags holds sticky flags, lost arbitration only after ARB_TRIES losses
    assign mstReq    = req_ff;
    assign mstRead   = rd_ff;
    assign mstAddr   = maddr_ff;
    assign mstOffset = moff_ff;
    assign mstWData  = mwd_ff;
    assign errFlags  = flags_ff;
    assign busy      = state_ff != SEA_IDLE;

endmodule

`default_nettype wire

// [sim/sea_access_props.sv]
// Purpose: checker for master-side timing and error flags of the decoder
// Assumes: bound to sea_access_decoder, one clock domain watched
// Notes:   consecutive lost arbitrations are counted in helper logic
`default_nettype none
module sea_access_props
    import sea_pkg::*;
#(
    parameter int ARB_TRIES = 16
) (
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic              mstReq,
    input wire logic              mstRead,
    input wire logic [6:0]        mstAddr,
    input wire logic [15:0]       mstOffset,
    input wire logic [7:0]        mstWData,
    input wire logic              mstDone,
    input wire logic              mstNoAck,
    input wire logic              mstLostArb,
    input wire logic              mstMisplaced,
    input wire logic              busy,
    input wire logic [ERR_W-1:0]  errFlags
);
    logic [4:0] arbCnt_ff;
    logic [4:0] nxt_arbCnt;
    logic       ended;
    assign ended = mstReq && mstDone;
    // lost tries in a row, back to zero on any other result or the last try
    always_comb begin
        nxt_arbCnt = arbCnt_ff;
        if (ended) begin
            nxt_arbCnt = (mstLostArb && arbCnt_ff != 5'(ARB_TRIES - 1)) ? arbCnt_ff + 5'h01 : 5'h00;
        end
    end
    always_ff @(posedge clk_sys) begin
        arbCnt_ff <= rst ? 5'h00 : nxt_arbCnt;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    fields_held_a: assert property (mstReq && $past(mstReq)
        |-> $stable({mstRead, mstAddr, mstOffset, mstWData})) else $error("fields moved");
    req_drop_a: assert property (ended && !mstLostArb |=> !mstReq)
        else $error("request not dropped");
    busy_cover_a: assert property (mstReq |-> busy) else $error("request while idle");
    noack_set_a: assert property (ended && mstNoAck |=> errFlags[ERR_NOACK])
        else $error("no ack flag missing");
    misplaced_set_a: assert property (ended && mstMisplaced |=> errFlags[ERR_MISPLACED])
        else $error("misplaced flag missing");
    arb_retry_a: assert property (ended && mstLostArb && arbCnt_ff != 5'(ARB_TRIES - 1)
        |=> !mstReq ##[1:2] mstReq) else $error("no retry");
    arb_giveup_a: assert property (ended && mstLostArb && arbCnt_ff == 5'(ARB_TRIES - 1)
        |=> !mstReq && errFlags[ERR_LOSTARB]) else $error("no give up");
    flag_cause_a: assert property (|(errFlags & ~$past(errFlags)) |-> $past(mstDone))
        else $error("flag without attempt");
    cover property (ended && mstRead && !mstNoAck);
    cover property (ended && mstLostArb && arbCnt_ff == 5'(ARB_TRIES - 1));
    cover property (ended && mstNoAck);
endmodule
bind sea_access_decoder sea_access_props #(.ARB_TRIES(ARB_TRIES)) u_props (
    .clk_sys(clk_sys), .rst(rst), .mstReq(mstReq), .mstRead(mstRead), .mstAddr(mstAddr),
    .mstOffset(mstOffset), .mstWData(mstWData), .mstDone(mstDone), .mstNoAck(mstNoAck),
    .mstLostArb(mstLostArb), .mstMisplaced(mstMisplaced), .busy(busy), .errFlags(errFlags));
`default_nettype wire

// [sim/sea_mem_model.sv]
// Purpose: master bus engine with a small memory behind it
// Assumes: one attempt answered three cycles after the request is seen
// Notes:   errMode 1 no ack, 2 lost arbitration, 3 misplaced condition
`default_nettype none
module sea_mem_model (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        mstReq,
    input wire logic        mstRead,
    input wire logic [6:0]  mstAddr,
    input wire logic [15:0] mstOffset,
    input wire logic [7:0]  mstWData,
    input wire logic [1:0]  errMode,
    output logic            mstDone,
    output logic [7:0]      mstRData,
    output logic            mstNoAck,
    output logic            mstLostArb,
    output logic            mstMisplaced
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [16];
    logic [6:0]  lastAddr;
    logic [15:0] lastOffset;
    logic        lastRead;
    logic [1:0]  waitCnt;
    int          attempts;
    initial begin
        {mstDone, mstNoAck, mstLostArb, mstMisplaced, waitCnt, mstRData} = '0;
        attempts = 0;
    end
    // results only valid with done; read data toggles otherwise
    always @(posedge clk_sys) begin
        {mstDone, mstNoAck, mstLostArb, mstMisplaced} <= 4'h0;
        mstRData <= ~mstRData;
        if (rst) begin
            waitCnt <= 2'h0;
        end else if (mstReq && !mstDone) begin
            waitCnt <= waitCnt + 2'h1;
            if (waitCnt == 2'h2) begin
                waitCnt <= 2'h0;
                mstDone <= 1'b1;
                attempts <= attempts + 1;
                {lastAddr, lastOffset, lastRead} <= {mstAddr, mstOffset, mstRead};
                mstNoAck <= errMode == 2'h1;
                mstLostArb <= errMode == 2'h2;
                mstMisplaced <= errMode == 2'h3;
                if (errMode == 2'h0 && mstRead) mstRData <= mem[mstOffset[3:0]];
                if (errMode == 2'h0 && !mstRead) mem[mstOffset[3:0]] <= mstWData;
            end
        end
    end
endmodule
`default_nettype wire

// [sim/tb.sv]
// Purpose: self-checking bench for the memory access decoder
// Assumes: link inputs driven on the falling link edge
// Notes:   reset held long enough for both clocks to see it
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sea_pkg::*;
    logic clk_sys = 0, clkLink = 0, rst = 1, frameStart = 0, frameStop = 0, blockMode = 0;
    logic rxValid = 0, txReq = 0, mstReq, mstRead, mstDone, mstNoAck, mstLostArb;
    logic mstMisplaced, busy;
    logic [7:0] rxByte = 0, txByte, mstWData, mstRData;
    logic [6:0] memIntfAddr = 7'h51, mstAddr;
    logic [15:0] mstOffset;
    logic [1:0] errMode = 0;
    logic [ERR_W-1:0] errFlags;
    int error_cnt = 0, cmp_count = 0;
    always #4 clk_sys = ~clk_sys;
    initial #7 forever #15 clkLink = ~clkLink;
    // every bench signal carries its port's name
    sea_access_decoder dut (.*);
    sea_mem_model far (.*);
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // host write part: count 5 covers cmd, addr, offsets and data
    task automatic send(input logic blk, input logic [7:0] code, cmd, ea, lo, hi, d);
        logic [7:0] b [7];
        b = '{code, 8'h05, cmd, ea, lo, hi, d};
        @(negedge clkLink);
        blockMode = blk;
        frameStart = 1;
        @(negedge clkLink);
        frameStart = 0;
        for (int i = 0; i < 7; i++) begin
            if (blk || i != 1) begin
                rxValid = 1;
                rxByte = b[i];
                @(negedge clkLink);
            end
        end
        rxValid = 0;
        frameStop = 1;
        @(negedge clkLink);
        frameStop = 0;
    endtask
    // bounded wait for the sequencer to start and go idle again
    task automatic wait_done();
        int n;
        logic seen;
        seen = 0;
        for (n = 0; n < 1000 && !(seen && busy === 1'b0); n++) begin
            @(negedge clk_sys);
            seen |= busy === 1'b1;
        end
        if (n == 1000) begin
            error_cnt++;
            $display("[FAIL] %0t sequencer hang", $time);
            tally_and_finish();
        end
        repeat (8) @(negedge clkLink); // reply crossing has no visible done
    endtask
    // host read part; word transfers start at the status byte
    task automatic reply(input logic blk, input logic [7:0] e [6]);
        @(negedge clkLink);
        blockMode = blk;
        frameStart = 1;
        @(negedge clkLink);
        frameStart = 0;
        txReq = 1;
        for (int i = blk ? 0 : 1; i < 6; i++) begin
            @(negedge clkLink);
            chk(txByte, e[i], "reply byte");
        end
        txReq = 0;
    endtask
    task automatic t_write();
        send(1, CODE_MEMORY, 8'h00, 8'ha6, 8'h03, 8'h12, 8'h5a);
        wait_done();
        chk(far.lastRead, OP_WRITE, "op");
        chk(far.lastAddr, memIntfAddr, "config addr");
        chk(far.lastOffset, 16'h1203, "offset");
        chk(far.mem[3], 8'h5a, "written");
    endtask
    task automatic t_read();
        send(0, CODE_MEMORY, 8'h03, 8'ha6, 8'h03, 8'h12, 8'h00);
        wait_done();
        chk(far.lastRead, OP_READ, "op");
        chk(far.lastAddr, 7'h53, "given addr");
        reply(1, '{8'h05, 8'h03, 8'ha6, 8'h03, 8'h12, 8'h5a});
    endtask
    task automatic t_errors();
        for (int m = 1; m < 4; m++) begin
            errMode = 2'(m);
            far.attempts = 0;
            send(0, CODE_MEMORY, 8'h01, 8'ha6, 8'h03, 8'h12, 8'h00);
            wait_done();
            chk(errFlags, 16'h1 << (m - 1), "flags");
            if (m == 2) chk(far.attempts, ARB_LIMIT, "tries");
            reply(0, '{8'h00, 8'h01 | (8'h04 << m), 8'ha6, 8'h03, 8'h12, 8'h5a});
            reply(0, '{8'h00, 8'h01, 8'ha6, 8'h03, 8'h12, 8'h5a});
            chk(errFlags, 16'h0, "flags cleared");
        end
        errMode = 0;
    endtask
    task automatic t_badcode();
        int hits;
        hits = 0;
        send(1, CODE_MEMORY ^ 8'h03, 8'h00, 8'ha6, 8'h04, 8'h00, 8'h11);
        repeat (200) begin
            @(negedge clk_sys);
            hits += int'(busy !== 1'b0);
        end
        chk(16'(hits), 16'h0, "foreign code ran");
    endtask
    initial begin
        repeat (16) @(negedge clk_sys); // both clocks see at least four edges
        rst = 0;
        repeat (6) @(negedge clkLink);
        t_write();
        t_read();
        t_errors();
        t_badcode();
        tally_and_finish();
    end
endmodule
`default_nettype wire
